/* test/fast_serial_port_tb.sv */
/* self-checking bench for the fast serial port: registers, pin directions, frames both ways.
   assumes tdm_far_end as the line partner and pull-ups on the three transmit pins. */
`include "fast_serial_port_params.svh"
module fast_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fast_serial_port_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rd_q = 1'b0, mode = 1'b0;
  addr_t addr = 8'h00;
  word_t wr_data = 32'h0, rd_data, v;
  logic txc_o, txc_oe, txf_o, txf_oe, txd_o, txd_oe, rxc_o, rxc_oe, rxf_o, rxf_oe, p_clk, p_fs, p_sd;
  logic [7:0] got_byte;
  word_t exp_q[$];
  logic [7:0] tx_q[$];
  int err_total = 0, comparisons = 0, cyc = 0, got_cnt;
  // released transmit pins float up through their pull-ups, released receive pins follow the far end
  wire txc = txc_oe ? txc_o : 1'b1;
  wire txf = txf_oe ? txf_o : 1'b1;
  wire txd = txd_oe ? txd_o : 1'b1;
  wire rxc = rxc_oe ? rxc_o : p_clk;
  wire rxf = rxf_oe ? rxf_o : p_fs;
  wire [4:0] oes = {txd_oe, rxf_oe, txf_oe, rxc_oe, txc_oe};
  always #4 clk = ~clk;
  fast_serial_port dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
    .RD_EN(rd_en), .RD_DATA(rd_data), .TX_BIT_CLOCK_I(txc), .TX_BIT_CLOCK_O(txc_o),
    .TX_BIT_CLOCK_OE(txc_oe), .TX_FRAME_SYNC_I(txf), .TX_FRAME_SYNC_O(txf_o),
    .TX_FRAME_SYNC_OE(txf_oe), .TX_SERIAL_DATA_I(txd), .TX_SERIAL_DATA_O(txd_o),
    .TX_SERIAL_DATA_OE(txd_oe), .RX_BIT_CLOCK_I(rxc), .RX_BIT_CLOCK_O(rxc_o),
    .RX_BIT_CLOCK_OE(rxc_oe), .RX_FRAME_SYNC_I(rxf), .RX_FRAME_SYNC_O(rxf_o),
    .RX_FRAME_SYNC_OE(rxf_oe), .RX_SERIAL_DATA(p_sd));
  tdm_far_end fe (.tx_clk(txc), .tx_fs(txf), .tx_fs_oe(txf_oe), .tx_sd(txd), .tx_fall(mode),
    .rx_clk(p_clk), .rx_fs(p_fs), .rx_sd(p_sd), .got_byte(got_byte), .got_cnt(got_cnt));
  task automatic check(input word_t got, input word_t exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input addr_t a, input word_t e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd
  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd_en;
  always @(negedge clk) if (rd_q) check(rd_data, exp_q.pop_front());
    else if (rst_n) check(rd_data, 32'h0);  // idle cycles read as zero
  always @(negedge clk) if (txd_oe === 1'b1) check({31'h0, txd_o}, 32'h0);
  always @(got_cnt) if (tx_q.size() > 0) check({24'h0, got_byte}, {24'h0, tx_q.pop_front()});
  // hang guard, far above the roughly 1200 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    void'($urandom(77493));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({27'h0, oes}, 32'h0);
    rd(`A_CTRL, 32'h0);
    rd(`A_DIV, 32'h1010);
    rd(`A_FRAME, 32'h1f);
    repeat (4) begin
      v = $urandom & 32'hf;
      wr(`A_CTRL, v);
      @(negedge clk);
      check({27'h0, oes}, v);
    end
    wr(`A_CTRL, 32'h0);
    wr(`A_FRAME, 32'h7);
    for (int m = 0; m < 2; m++) begin
      v = $urandom;
      mode <= m[0];
      wr(`A_TXDATA, {24'h0, v[7:0]});
      tx_q.push_back(v[7:0]);
      wr(`A_TXDATA, {24'h0, v[15:8]});
      tx_q.push_back(v[15:8]);
      wr(`A_CTRL, 32'h45 | (m << 4) | (m << 5));
      fe.send(v[23:16], m[0]);
      repeat (8) @(posedge clk);
      rd(`A_RXDATA, {23'h0, 1'b1, v[23:16]});
      for (int k = 0; k < 3000 && tx_q.size() > 0; k++) @(posedge clk);
      check(32'(tx_q.size()), 32'h0);
      // let the empty FIFO reach the next byte boundary: underrun, both running, data released
      repeat (48) @(posedge clk);
      rd(`A_STATUS, 32'h78);
      wr(`A_CTRL, 32'h0);
    end
    wr(`A_CTRL, 32'h4f);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({27'h0, oes}, 32'h0);
    conclude();
  end
endmodule : fast_serial_port_tb

/* test/tdm_far_end.sv */
/* far-end tdm device: drives receive clock, sync and data, listens to the transmit pins.
   assumes the transmit pins arrive already resolved with their pull-ups. */
module tdm_far_end (
  // transmit line as seen from outside
  input  wire logic tx_clk,
  input  wire logic tx_fs,
  input  wire logic tx_fs_oe,
  input  wire logic tx_sd,
  input  wire logic tx_fall,
  // receive line driven into the port
  output logic       rx_clk,
  output logic       rx_fs,
  output logic       rx_sd,
  // last whole transmit byte and how many arrived
  output logic [7:0] got_byte,
  output int         got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 62;  // half bit time in ns, keeps the clock under the top rate
  logic [7:0] sh = 8'h00;  // bits of the frame so far
  int         idx = 8;     // bit position, 8 while idle
  initial begin
    rx_clk = 1'b1;  // clock stands still high between frames
    rx_fs = 1'b0;
    rx_sd = 1'b1;
    got_byte = 8'h00;
    got_cnt = 0;
  end
  // sample on the edge opposite to the launch edge
  always @(tx_clk) begin
    if (tx_fs_oe && tx_clk == tx_fall) begin
      if (tx_fs) idx = 0;
      if (idx < 8) begin
        sh = {sh[6:0], tx_sd};  // msb first
        if (idx == 7) begin
          got_byte = sh;
          got_cnt++;
        end
        idx++;
      end
    end
  end
  // a stale partial frame must not survive a disable
  always @(negedge tx_fs_oe) idx = 8;
  // one 8-bit frame, sync high over bit 0
  task automatic send(input logic [7:0] b, input logic fall);
    for (int i = 0; i < 8; i++) begin
      rx_clk = !fall;  // sample edge of the previous bit
      #HALF;
      rx_clk = fall;
      rx_fs = (i == 0);
      rx_sd = b[7-i];
      #HALF;
    end
    rx_clk = !fall;
    #HALF;
    rx_fs = 1'b0;
    rx_sd = 1'b1;  // driven high as the idle level, the receive data line has no pull-up
    rx_clk = 1'b1;
    #HALF;
  endtask : send
endmodule : tdm_far_end

/* verilog/fast_serial_port.sv */
/* fast serial port: framed TDM transmit and receive over bit clock, frame sync and data pins,
   with a register port, an 8-byte transmit FIFO and a one-byte receive holding register.
   assumes pins come from another clock domain and that bus strobes are one cycle long. */
`include "fast_serial_port_params.svh"
module fast_serial_port (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // register port
  input  wire fast_serial_port_pkg::addr_t ADDR,
  input  wire fast_serial_port_pkg::word_t WR_DATA,
  input  wire logic                  WR_EN,
  input  wire logic                  RD_EN,
  output fast_serial_port_pkg::word_t      RD_DATA,
  // transmit pins
  input  wire logic                  TX_BIT_CLOCK_I,
  output logic                       TX_BIT_CLOCK_O,
  output logic                       TX_BIT_CLOCK_OE,
  input  wire logic                  TX_FRAME_SYNC_I,
  output logic                       TX_FRAME_SYNC_O,
  output logic                       TX_FRAME_SYNC_OE,
  input  wire logic                  TX_SERIAL_DATA_I,
  output logic                       TX_SERIAL_DATA_O,
  output logic                       TX_SERIAL_DATA_OE,
  // receive pins
  input  wire logic                  RX_BIT_CLOCK_I,
  output logic                       RX_BIT_CLOCK_O,
  output logic                       RX_BIT_CLOCK_OE,
  input  wire logic                  RX_FRAME_SYNC_I,
  output logic                       RX_FRAME_SYNC_O,
  output logic                       RX_FRAME_SYNC_OE,
  input  wire logic                  RX_SERIAL_DATA
);
  import fast_serial_port_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // keep a programmed half period inside the legal bit clock range
  function automatic byte_t clamp_half(input byte_t raw);
    if (raw < 8'(`HALF_MIN)) begin
      clamp_half = 8'(`HALF_MIN);
    end else if (raw > 8'(`HALF_MAX)) begin
      clamp_half = 8'(`HALF_MAX);
    end else begin
      clamp_half = raw;
    end
  endfunction : clamp_half

  // saturating bit counter step, so long frames never wrap to zero
  function automatic byte_t bump(input byte_t c);
    bump = (c == 8'hff) ? c : c + 8'h01;
  endfunction : bump

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam int TXC = 0;            // synchroniser lanes
  localparam int RXC = 1;
  localparam int TXF = 2;
  localparam int RXF = 3;
  localparam int RXD = 4;
  localparam int TXD = 5;
  logic [6:0]  ctrl_q;               // directions, edges, enable
  logic [15:0] div_q;                // rx half period : tx half period
  byte_t       flen_q;               // index of the last bit in a frame
  logic        rx_over_q;            // sticky receive overrun
  logic        tx_under_q;           // sticky transmit underrun
  word_t       rd_d;                 // read mux
  logic        en;
  logic [5:0]  s_lvl;                // filtered pin levels
  logic [5:0]  s_rise;
  logic [5:0]  s_fall;
  byte_t       dcnt_q [2];           // divider counters, 0 tx, 1 rx
  logic [1:0]  dlvl_q;               // generated clock levels
  logic [1:0]  dwrap;
  logic [1:0]  brise;                // bit clock edges as used
  logic [1:0]  bfall;
  logic        tx_launch;
  logic        rx_sample;
  logic        rx_opp;               // receive edge opposite to sampling
  link_state_t tx_st_q;
  byte_t       tx_cnt_q;
  byte_t       tx_sh_q;
  logic        tx_fs_o_q;
  logic        tx_oe_q;
  logic        od_low_q;             // pad data held low
  logic        tx_start;
  logic        tx_load;
  logic        tx_bit;
  link_state_t rx_st_q;
  byte_t       rx_cnt_q;
  byte_t       rx_sh_q;
  logic        rx_fs_o_q;
  logic        rx_start;
  logic        rx_push;
  byte_t       rx_hold_q;
  logic        rx_full_q;
  logic        rd_rx;
  stream_if #(.W(8)) push_if ();     // bus into FIFO
  stream_if #(.W(8)) pop_if ();      // FIFO into transmitter

  assign en = ctrl_q[`F_ENABLE];

  // ----------------------------------------
  // pin synchronisers and FIFO
  // ----------------------------------------
  pin_sync #(.N(6)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .pin   ({TX_SERIAL_DATA_I, RX_SERIAL_DATA, RX_FRAME_SYNC_I, TX_FRAME_SYNC_I, RX_BIT_CLOCK_I, TX_BIT_CLOCK_I}),
    .level (s_lvl),
    .rise  (s_rise),
    .fall  (s_fall)
  );

  // a full FIFO refuses the byte; software sees it in the full flag
  assign push_if.valid = WR_EN && (ADDR == `A_TXDATA);
  assign push_if.data  = WR_DATA[7:0];
  stream_fifo #(.W(8), .DEPTH(8)) u_fifo (
    .clk   (CLK),
    .rst_n (RST_N),
    .wr    (push_if),
    .rd    (pop_if)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // configuration; every direction starts as input
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_q <= `CTRL_RST;
      div_q  <= `DIV_RST;
      flen_q <= `FRAME_RST;
    end else if (WR_EN && ADDR == `A_CTRL) begin
      ctrl_q <= WR_DATA[6:0];
    end else if (WR_EN && ADDR == `A_DIV) begin
      div_q  <= WR_DATA[15:0];
    end else if (WR_EN && ADDR == `A_FRAME) begin
      flen_q <= WR_DATA[7:0];
    end
  end

  // sticky errors: write one to clear, a new event wins over the clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_over_q  <= 1'b0;
      tx_under_q <= 1'b0;
    end else begin
      if (rx_push && rx_full_q && !rd_rx) begin
        rx_over_q <= 1'b1;
      end else if (WR_EN && ADDR == `A_STATUS && WR_DATA[`F_RX_OVERRUN]) begin
        rx_over_q <= 1'b0;
      end
      if (tx_load && !pop_if.valid) begin
        tx_under_q <= 1'b1;
      end else if (WR_EN && ADDR == `A_STATUS && WR_DATA[`F_TX_UNDERRUN]) begin
        tx_under_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register reads, data one cycle after the strobe
  // ----------------------------------------
  assign rd_rx = RD_EN && (ADDR == `A_RXDATA);
  always_comb begin
    rd_d = '0;
    if (ADDR == `A_CTRL) begin
      rd_d[6:0] = ctrl_q;
    end else if (ADDR == `A_DIV) begin
      rd_d[15:0] = div_q;
    end else if (ADDR == `A_FRAME) begin
      rd_d[7:0] = flen_q;
    end else if (ADDR == `A_RXDATA) begin
      rd_d[7:0]          = rx_hold_q;
      rd_d[`F_RXD_VALID] = rx_full_q;
    end else if (ADDR == `A_STATUS) begin
      rd_d[`F_TX_FULL]     = !push_if.ready;
      rd_d[`F_RX_VALID]    = rx_full_q;
      rd_d[`F_RX_OVERRUN]  = rx_over_q;
      rd_d[`F_TX_UNDERRUN] = tx_under_q;
      rd_d[`F_TX_RUN]      = (tx_st_q == LINK_RUN);
      rd_d[`F_RX_RUN]      = (rx_st_q == LINK_RUN);
      rd_d[`F_TXD_LEVEL]   = s_lvl[TXD];
    end
  end

  // unmapped addresses and idle cycles read as zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RD_DATA <= '0;
    end else begin
      RD_DATA <= RD_EN ? rd_d : '0;
    end
  end

  // ----------------------------------------
  // bit clock dividers, used when a clock pin is an output
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      dwrap[i] = (dcnt_q[i] == clamp_half(div_q[8*i +: 8]) - 8'h01);
    end
  end

  // the clamp keeps a generated clock inside the legal range whatever is written
  always_ff @(posedge CLK) begin
    for (int i = 0; i < 2; i++) begin
      if (!RST_N || !en || !ctrl_q[i]) begin
        dcnt_q[i] <= 8'h00;
        dlvl_q[i] <= 1'b0;
      end else if (dwrap[i]) begin
        dcnt_q[i] <= 8'h00;
        dlvl_q[i] <= !dlvl_q[i];
      end else begin
        dcnt_q[i] <= dcnt_q[i] + 8'h01;
      end
    end
  end

  // pick the edge source: own divider when driving, pin edges otherwise
  always_comb begin
    brise[0] = ctrl_q[`F_TXCLK_OUT] ? (dwrap[0] && !dlvl_q[0]) : s_rise[TXC];
    bfall[0] = ctrl_q[`F_TXCLK_OUT] ? (dwrap[0] && dlvl_q[0]) : s_fall[TXC];
    brise[1] = ctrl_q[`F_RXCLK_OUT] ? (dwrap[1] && !dlvl_q[1]) : s_rise[RXC];
    bfall[1] = ctrl_q[`F_RXCLK_OUT] ? (dwrap[1] && dlvl_q[1]) : s_fall[RXC];
  end
  assign tx_launch = en && (ctrl_q[`F_TX_FALL] ? bfall[0] : brise[0]);
  assign rx_sample = en && (ctrl_q[`F_RX_FALL] ? bfall[1] : brise[1]);
  assign rx_opp    = en && (ctrl_q[`F_RX_FALL] ? brise[1] : bfall[1]);

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  // frame start comes from our own count or from the partner's sync
  assign tx_start = ctrl_q[`F_TXFS_OUT] ? (tx_st_q != LINK_RUN || tx_cnt_q == flen_q)
                                       : s_lvl[TXF];
  // a new byte is fetched at bit zero and at every eighth bit
  assign tx_load = tx_launch && tx_st_q != LINK_OFF &&
                   (tx_start || (tx_st_q == LINK_RUN && tx_cnt_q != flen_q && tx_cnt_q[2:0] == 3'h7));
  assign pop_if.ready = tx_load;
  // an empty FIFO sends ones, which leaves the line released
  assign tx_bit = tx_load ? (pop_if.valid ? pop_if.data[7] : 1'b1) : tx_sh_q[7];

  always_ff @(posedge CLK) begin
    if (!RST_N || !en) begin
      tx_st_q   <= LINK_OFF;
      tx_cnt_q  <= 8'h00;
      tx_sh_q   <= 8'hff;
      tx_fs_o_q <= 1'b0;
      tx_oe_q   <= 1'b0;
    end else if (tx_st_q == LINK_OFF) begin
      tx_st_q <= LINK_HUNT;
    end else if (tx_launch) begin
      if (tx_start || (tx_st_q == LINK_RUN && tx_cnt_q != flen_q)) begin
        tx_st_q   <= LINK_RUN;
        tx_cnt_q  <= tx_start ? 8'h00 : bump(tx_cnt_q);
        tx_fs_o_q <= tx_start && ctrl_q[`F_TXFS_OUT];
        tx_oe_q   <= !tx_bit;
        if (tx_load) begin
          tx_sh_q <= pop_if.valid ? {pop_if.data[6:0], 1'b1} : 8'hff;
        end else begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b1};
        end
      end else begin
        // past the last bit with no new sync: release and wait
        tx_st_q   <= LINK_HUNT;
        tx_fs_o_q <= 1'b0;
        tx_oe_q   <= 1'b0;
      end
    end
  end

  // the pad only ever pulls low, so its data stays zero
  always_ff @(posedge CLK) begin
    od_low_q <= 1'b0;
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign rx_start = ctrl_q[`F_RXFS_OUT] ? (rx_st_q != LINK_RUN || rx_cnt_q == flen_q)
                                       : s_lvl[RXF];
  // a byte is complete when the eighth bit of a group arrives
  assign rx_push = rx_sample && !rx_start && rx_st_q == LINK_RUN &&
                   rx_cnt_q != flen_q && rx_cnt_q[2:0] == 3'h6;

  always_ff @(posedge CLK) begin
    if (!RST_N || !en) begin
      rx_st_q  <= LINK_OFF;
      rx_cnt_q <= 8'h00;
      rx_sh_q  <= 8'h00;
    end else if (rx_st_q == LINK_OFF) begin
      rx_st_q <= LINK_HUNT;
    end else if (rx_sample) begin
      if (rx_start) begin
        rx_st_q  <= LINK_RUN;
        rx_cnt_q <= 8'h00;
        rx_sh_q  <= {7'h00, s_lvl[RXD]};
      end else if (rx_st_q == LINK_RUN && rx_cnt_q != flen_q) begin
        rx_cnt_q <= bump(rx_cnt_q);
        rx_sh_q  <= {rx_sh_q[6:0], s_lvl[RXD]};
      end else begin
        rx_st_q <= LINK_HUNT;
      end
    end
  end

  // driven sync goes out on the edge before the sampling edge of bit zero
  always_ff @(posedge CLK) begin
    if (!RST_N || !en) begin
      rx_fs_o_q <= 1'b0;
    end else if (rx_opp) begin
      rx_fs_o_q <= ctrl_q[`F_RXFS_OUT] && (rx_st_q != LINK_RUN || rx_cnt_q == flen_q);
    end
  end

  // holding register: a push in the cycle of a read still lands
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_hold_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (rx_push) begin
      rx_hold_q <= {rx_sh_q[6:0], s_lvl[RXD]};
      rx_full_q <= 1'b1;
    end else if (rd_rx) begin
      rx_full_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign TX_BIT_CLOCK_O    = dlvl_q[0];
  assign TX_BIT_CLOCK_OE   = ctrl_q[`F_TXCLK_OUT];
  assign TX_FRAME_SYNC_O   = tx_fs_o_q;
  assign TX_FRAME_SYNC_OE  = ctrl_q[`F_TXFS_OUT];
  assign TX_SERIAL_DATA_O  = od_low_q;
  assign TX_SERIAL_DATA_OE = tx_oe_q;
  assign RX_BIT_CLOCK_O    = dlvl_q[1];
  assign RX_BIT_CLOCK_OE   = ctrl_q[`F_RXCLK_OUT];
  assign RX_FRAME_SYNC_O   = rx_fs_o_q;
  assign RX_FRAME_SYNC_OE  = ctrl_q[`F_RXFS_OUT];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  tx_fs_dir_a: assert property (WR_EN && ADDR == `A_CTRL |=> TX_FRAME_SYNC_OE == $past(WR_DATA[`F_TXFS_OUT]))
    else $error("tx frame sync direction not taken from write");
  rx_fs_dir_a: assert property (WR_EN && ADDR == `A_CTRL |=> RX_FRAME_SYNC_OE == $past(WR_DATA[`F_RXFS_OUT]))
    else $error("rx frame sync direction not taken from write");
  tx_open_drain_a: assert property (!TX_SERIAL_DATA_O && (TX_SERIAL_DATA_OE -> tx_st_q == LINK_RUN))
    else $error("tx data driven high or outside a frame");
  tx_clk_range_a: assert property (dwrap[0] |-> dcnt_q[0] >= 8'(`HALF_MIN - 1) && dcnt_q[0] <= 8'(`HALF_MAX - 1))
    else $error("tx bit clock half period out of range");
  tx_edge_sel_a: assert property (tx_launch && !ctrl_q[`F_TXCLK_OUT] |->
      s_lvl[TXC] == !ctrl_q[`F_TX_FALL] && $past(s_lvl[TXC]) == ctrl_q[`F_TX_FALL])
    else $error("tx launch on wrong clock edge");
  rx_edge_sel_a: assert property (rx_sample && !ctrl_q[`F_RXCLK_OUT] |->
      s_lvl[RXC] == !ctrl_q[`F_RX_FALL] && $past(s_lvl[RXC]) == ctrl_q[`F_RX_FALL])
    else $error("rx sample on wrong clock edge");
  rx_clk_range_a: assert property (dwrap[1] |-> dcnt_q[1] >= 8'(`HALF_MIN - 1) && dcnt_q[1] <= 8'(`HALF_MAX - 1))
    else $error("rx bit clock half period out of range");
  dir_reset_a: assert property ($past(!RST_N) |->
      !(TX_BIT_CLOCK_OE || RX_BIT_CLOCK_OE || TX_FRAME_SYNC_OE || RX_FRAME_SYNC_OE))
    else $error("a direction is not input after reset");
  tx_frame_start_a: assert property (en && tx_launch && tx_start && tx_st_q != LINK_OFF |=>
      tx_cnt_q == 8'h00 && tx_st_q == LINK_RUN)
    else $error("tx count did not restart at frame sync");
  rx_frame_start_a: assert property (en && rx_sample && rx_start && rx_st_q != LINK_OFF |=>
      rx_cnt_q == 8'h00 && rx_st_q == LINK_RUN)
    else $error("rx count did not restart at frame sync");

  tx_byte_c:   cover property (tx_load && pop_if.valid);
  rx_byte_c:   cover property (rx_push);
  rx_over_c:   cover property (rx_push && rx_full_q && !rd_rx);
  tx_fs_out_c: cover property (tx_fs_o_q && ctrl_q[`F_TX_FALL]);
endmodule : fast_serial_port

/* verilog/fast_serial_port_params.svh */
/* offsets, field positions, reset values and timing counts of the fast serial port.
   assumes it is included by bare name and that the block clock runs at 125 MHz. */
`ifndef FAST_SERIAL_PORT_PARAMS_SVH
`define FAST_SERIAL_PORT_PARAMS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define A_CTRL        8'h00
`define A_DIV         8'h04
`define A_FRAME       8'h08
`define A_TXDATA      8'h0c
`define A_RXDATA      8'h10
`define A_STATUS      8'h14
// ----------------------------------------
// field positions
// ----------------------------------------
`define F_TXCLK_OUT   0
`define F_RXCLK_OUT   1
`define F_TXFS_OUT    2
`define F_RXFS_OUT    3
`define F_TX_FALL     4
`define F_RX_FALL     5
`define F_ENABLE      6
`define F_TX_FULL     0
`define F_RX_VALID    1
`define F_RX_OVERRUN  2
`define F_TX_UNDERRUN 3
`define F_TX_RUN      4
`define F_RX_RUN      5
`define F_TXD_LEVEL   6
`define F_RXD_VALID   8
// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RST      7'h00
`define DIV_RST       16'h1010
`define FRAME_RST     8'h1f
// ----------------------------------------
// timing: bit clock range in hertz, half periods in block clocks
// ----------------------------------------
`define CLK_HZ        125000000
`define BCLK_MIN_HZ   512000
`define BCLK_MAX_HZ   8192000
`define HALF_MIN      ((`CLK_HZ + 2 * `BCLK_MAX_HZ - 1) / (2 * `BCLK_MAX_HZ))
`define HALF_MAX      (`CLK_HZ / (2 * `BCLK_MIN_HZ))
`endif

/* verilog/fast_serial_port_pkg.sv */
/* types shared by the fast serial port modules.
   assumes nothing beyond a SystemVerilog compiler. */
package fast_serial_port_pkg;
  typedef logic [7:0]  addr_t;   // register byte address
  typedef logic [31:0] word_t;   // bus data word
  typedef logic [7:0]  byte_t;   // serial byte and counts
  // link engine states: off while disabled, hunting for a frame, running
  typedef enum logic [1:0] {LINK_OFF, LINK_HUNT, LINK_RUN} link_state_t;
endpackage : fast_serial_port_pkg

/* verilog/pin_sync.sv */
/* three-stage pin synchroniser with agreement filter and edge pulses.
   assumes pins are asynchronous to clk and change slower than a few clocks. */
module pin_sync #(
  parameter int N = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins and filtered view
  input  wire logic [N-1:0] pin,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);
  logic [N-1:0] s1_q;   // first stage, read only by s2_q
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] agree;
  logic [N-1:0] lvl_d;
  // ----------------------------------------
  // shift chain
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a change counts only once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign lvl_d = (agree & s2_q) | (~agree & level);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= '0;
      rise  <= '0;
      fall  <= '0;
    end else begin
      level <= lvl_d;
      rise  <= lvl_d & ~level;
      fall  <= ~lvl_d & level;
    end
  end
endmodule : pin_sync

/* verilog/stream_fifo.sv */
/* synchronous FIFO, width and depth as parameters.
   assumes depth is a power of two and both sides share the clock. */
module stream_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling and draining sides
  stream_if.snk    wr,
  stream_if.src    rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];        // storage
  logic [AW:0]  wptr_q;             // write pointer with wrap bit
  logic [AW:0]  rptr_q;             // read pointer with wrap bit
  logic         full;
  logic         empty;
  // ----------------------------------------
  // flags: the wrap bit tells full from empty
  // ----------------------------------------
  assign empty    = (wptr_q == rptr_q);
  assign full     = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr_q[AW-1:0]];
  // write side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_q <= '0;
    end else if (wr.valid && !full) begin
      mem[wptr_q[AW-1:0]] <= wr.data;
      wptr_q              <= wptr_q + 1'b1;
    end
  end
  // read side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rptr_q <= '0;
    end else if (rd.ready && !empty) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end
endmodule : stream_fifo

/* verilog/stream_if.sv */
/* valid/ready stream carrier between the port and its FIFO.
   assumes a transfer happens when valid and ready are both high at a clock edge. */
interface stream_if #(parameter int W = 8);
  logic [W-1:0] data;   // payload
  logic         valid;  // source offers data
  logic         ready;  // sink accepts data
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : stream_if
